// File: rtl/nco_clk_if.sv
// Carries the selected input clock edge from the source selector to the core.
interface nco_clk_if;
  logic [1:0] clk_sel;
  logic tick;
  modport source (input clk_sel, output tick);
  modport core (output clk_sel, input tick);
endinterface

// File: rtl/nco_clk_select.sv
// Input clock source selector: synchronises the three sources and marks rising edges.
module nco_clk_select
(
  // System clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Candidate input clocks, asynchronous to pclk.
  input wire logic fast_internal_osc,
  input wire logic sys_osc_clk,
  input wire logic logic_cell_one_output,
  // Selection in, edge pulse out.
  nco_clk_if.source clk_bus
);
  import nco_pkg::*;

  logic [2:0] sync1_reg;
  logic [2:0] sync1_next;
  logic [2:0] sync2_reg;
  logic [2:0] sync2_next;
  logic prev_reg;
  logic prev_next;
  logic tick_reg;
  logic tick_next;
  logic chosen;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers, source mux and rising edge detect.
  // A source must stay below half the pclk rate or edges are lost, and a
  // change of selection may produce one spurious edge at the switch.
  always_comb
  begin
    sync1_next = {logic_cell_one_output, sys_osc_clk, fast_internal_osc};
    sync2_next = sync1_reg;
    case (clk_bus.clk_sel)
      CKS_FAST: chosen = sync2_reg[0];
      CKS_SYS: chosen = sync2_reg[1];
      CKS_LCELL: chosen = sync2_reg[2];
      default: chosen = 1'b0;
    endcase
    prev_next = chosen;
    tick_next = chosen & ~prev_reg;
  end

  // State registers.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      prev_reg <= 1'b0;
      tick_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      prev_reg <= prev_next;
      tick_reg <= tick_next;
    end
  end

  assign clk_bus.tick = tick_reg;

endmodule // nco_clk_select

// File: rtl/nco_pkg.sv
// Shared constants for the numerically controlled oscillator.
package nco_pkg;

  // Widths.
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int ACC_W = 20;
  localparam int PCNT_W = 8;

  // Register byte offsets on the APB.
  localparam logic [11:0] OFF_CONTROL = 12'h000;
  localparam logic [11:0] OFF_CLOCK = 12'h004;
  localparam logic [11:0] OFF_ACCL = 12'h008;
  localparam logic [11:0] OFF_ACCH = 12'h00C;
  localparam logic [11:0] OFF_ACCU = 12'h010;
  localparam logic [11:0] OFF_INCL = 12'h014;
  localparam logic [11:0] OFF_INCH = 12'h018;
  localparam logic [11:0] OFF_INCU = 12'h01C;
  localparam logic [11:0] OFF_PIN = 12'h020;

  // Field positions in the control register.
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_OUT_BIT = 5;
  localparam int CTL_POL_BIT = 4;
  localparam int CTL_PFM_BIT = 0;

  // Field positions in the clock control and pin registers.
  localparam int CLK_PWS_LSB = 5;
  localparam int CLK_CKS_LSB = 0;
  localparam int PIN_EN_BIT = 0;

  // Input clock select codes.
  localparam logic [1:0] CKS_FAST = 2'h0;
  localparam logic [1:0] CKS_SYS = 2'h1;
  localparam logic [1:0] CKS_LCELL = 2'h2;
  localparam logic [1:0] CKS_RSVD = 2'h3;

  // Reset values.
  localparam logic [19:0] ACC_RST = 20'h00000;
  localparam logic [19:0] INC_RST = 20'h00001;
  localparam logic [2:0] PWS_RST = 3'h0;
  localparam logic [1:0] CKS_RST = 2'h0;

  // Input clock edges from a low-byte increment write to the buffer load.
  localparam logic [1:0] LOAD_TICK_COUNT = 2'h2;

endpackage

// File: rtl/numeric_oscillator.sv
// Numerically controlled oscillator with a 20-bit phase accumulator behind an APB slave.

// Notes on behaviour
// - 20-bit accumulator readable and writable as bytes.
// - Each input clock edge adds buffered increment.
// - Adder runs from selected input clock edges.
// - Accumulator carry out is the overflow event.
// - Three input clock sources are selectable.
// - Select codes: fast, system, logic cell, reserved.
// - Increment is 20 bits in three bytes.
// - Increment is double-buffered behind hidden registers.
// - Enabled low-byte write loads buffer second edge.
// - Disabled: buffer loads right after any write.
// - Fixed duty mode toggles output per overflow.
// - Mode bit clear fixed duty, set pulse.
// - Pulse starts at overflow, lasts selected periods.
// - Pulse width field acts only in pulse mode.
// - Width code gives two-to-the-code input periods.
// - Width beyond overflow interval keeps output steady.
// - Active and inactive levels follow polarity.
// - Polarity bit set inverts the output.
// - Every overflow raises an event.
// - Output goes to peripherals and optional pin.
module numeric_oscillator
(
  // System clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [nco_pkg::ADDR_W-1:0] paddr,
  input wire logic [nco_pkg::DATA_W-1:0] pwdata,
  output logic [nco_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Input clock sources.
  input wire logic fast_internal_osc,
  input wire logic sys_osc_clk,
  input wire logic logic_cell_one_output,
  // Oscillator outputs.
  output logic osc_out,
  output logic accum_carry_event,
  output logic osc_pin_out,
  output logic osc_pin_oe
);
  import nco_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions.

  // True when the bus address selects the given register.
  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    return addr == off;
  endfunction

  // True for any implemented register address.
  function automatic logic mapped(input logic [ADDR_W-1:0] addr);
    return hit(addr, OFF_CONTROL) | hit(addr, OFF_CLOCK) | hit(addr, OFF_ACCL) | hit(addr, OFF_ACCH) |
      hit(addr, OFF_ACCU) | hit(addr, OFF_INCL) | hit(addr, OFF_INCH) | hit(addr, OFF_INCU) |
      hit(addr, OFF_PIN);
  endfunction

  // Active pulse length in input clock periods for a width code.
  function automatic logic [PCNT_W-1:0] pulse_span(input logic [2:0] code);
    return 8'h01 << code;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic ctl_en_reg;
  logic ctl_en_next;
  logic ctl_pol_reg;
  logic ctl_pol_next;
  logic ctl_pfm_reg;
  logic ctl_pfm_next;
  logic [2:0] pws_reg;
  logic [2:0] pws_next;
  logic [1:0] cks_reg;
  logic [1:0] cks_next;
  logic pin_en_reg;
  logic pin_en_next;
  logic [ACC_W-1:0] inc_reg;
  logic [ACC_W-1:0] inc_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;

  logic [ACC_W-1:0] acc_reg;
  logic [ACC_W-1:0] acc_next;
  logic [ACC_W-1:0] inc_buf_reg;
  logic [ACC_W-1:0] inc_buf_next;
  logic load_pending_reg;
  logic load_pending_next;
  logic [1:0] load_ticks_reg;
  logic [1:0] load_ticks_next;

  logic toggle_reg;
  logic toggle_next;
  logic active_reg;
  logic active_next;
  logic [PCNT_W-1:0] pulse_cnt_reg;
  logic [PCNT_W-1:0] pulse_cnt_next;
  logic out_reg;
  logic out_next;
  logic pin_out_reg;
  logic pin_out_next;
  logic pin_oe_reg;
  logic pin_oe_next;
  logic event_reg;
  logic event_next;

  logic wr_cycle;
  logic acc_wr;
  logic incl_wr;
  logic inc_any_wr;
  logic tick;
  logic tick_en;
  logic carry;
  logic raw_level;
  logic [ACC_W:0] acc_sum;
  logic [PCNT_W-1:0] span_now;

  nco_clk_if clk_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Input clock selection.

  // The selector turns the chosen asynchronous source into one-pclk edge pulses.
  nco_clk_select u_clk_select
  (
    .pclk(pclk),
    .presetn(presetn),
    .fast_internal_osc(fast_internal_osc),
    .sys_osc_clk(sys_osc_clk),
    .logic_cell_one_output(logic_cell_one_output),
    .clk_bus(clk_bus.source)
  );

  assign clk_bus.clk_sel = cks_reg;
  assign tick = clk_bus.tick;
  assign tick_en = tick & ctl_en_reg;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode and software-visible registers.

  // A write takes effect only at the access edge where pready is high.
  assign wr_cycle = psel & penable & pready_reg & pwrite;
  assign acc_wr = wr_cycle & (hit(paddr, OFF_ACCL) | hit(paddr, OFF_ACCH) | hit(paddr, OFF_ACCU));
  assign incl_wr = wr_cycle & hit(paddr, OFF_INCL);
  assign inc_any_wr = wr_cycle & (hit(paddr, OFF_INCL) | hit(paddr, OFF_INCH) | hit(paddr, OFF_INCU));

  // Read data is prepared in the setup cycle so the slave never inserts waits.
  always_comb
  begin
    ctl_en_next = ctl_en_reg;
    ctl_pol_next = ctl_pol_reg;
    ctl_pfm_next = ctl_pfm_reg;
    pws_next = pws_reg;
    cks_next = cks_reg;
    pin_en_next = pin_en_reg;
    inc_next = inc_reg;
    pready_next = psel & ~penable;
    pslverr_next = psel & ~penable & ~mapped(paddr);
    prdata_next = prdata_reg;
    if (psel & ~penable & ~pwrite)
    begin
      prdata_next = '0;
      case (paddr)
        OFF_CONTROL:
        begin
          prdata_next[CTL_EN_BIT] = ctl_en_reg;
          prdata_next[CTL_OUT_BIT] = out_reg;
          prdata_next[CTL_POL_BIT] = ctl_pol_reg;
          prdata_next[CTL_PFM_BIT] = ctl_pfm_reg;
        end
        OFF_CLOCK:
        begin
          prdata_next[CLK_PWS_LSB +: 3] = pws_reg;
          prdata_next[CLK_CKS_LSB +: 2] = cks_reg;
        end
        OFF_ACCL: prdata_next[7:0] = acc_reg[7:0];
        OFF_ACCH: prdata_next[7:0] = acc_reg[15:8];
        OFF_ACCU: prdata_next[3:0] = acc_reg[19:16];
        OFF_INCL: prdata_next[7:0] = inc_reg[7:0];
        OFF_INCH: prdata_next[7:0] = inc_reg[15:8];
        OFF_INCU: prdata_next[3:0] = inc_reg[19:16];
        OFF_PIN: prdata_next[PIN_EN_BIT] = pin_en_reg;
        default: prdata_next = '0;
      endcase
    end
    if (wr_cycle)
    begin
      case (paddr)
        OFF_CONTROL:
        begin
          ctl_en_next = pwdata[CTL_EN_BIT];
          ctl_pol_next = pwdata[CTL_POL_BIT];
          ctl_pfm_next = pwdata[CTL_PFM_BIT];
        end
        OFF_CLOCK:
        begin
          pws_next = pwdata[CLK_PWS_LSB +: 3];
          cks_next = pwdata[CLK_CKS_LSB +: 2];
        end
        OFF_INCL: inc_next[7:0] = pwdata[7:0];
        OFF_INCH: inc_next[15:8] = pwdata[7:0];
        OFF_INCU: inc_next[19:16] = pwdata[3:0];
        OFF_PIN: pin_en_next = pwdata[PIN_EN_BIT];
        default: inc_next = inc_reg;
      endcase
    end
  end

  // Register stage of the bus group.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_en_reg <= 1'b0;
      ctl_pol_reg <= 1'b0;
      ctl_pfm_reg <= 1'b0;
      pws_reg <= PWS_RST;
      cks_reg <= CKS_RST;
      pin_en_reg <= 1'b0;
      inc_reg <= INC_RST;
      prdata_reg <= '0;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      ctl_en_reg <= ctl_en_next;
      ctl_pol_reg <= ctl_pol_next;
      ctl_pfm_reg <= ctl_pfm_next;
      pws_reg <= pws_next;
      cks_reg <= cks_next;
      pin_en_reg <= pin_en_next;
      inc_reg <= inc_next;
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and increment buffer.

  // One extra bit keeps the carry that marks an overflow.
  assign acc_sum = {1'b0, acc_reg} + {1'b0, inc_buf_reg};
  assign carry = tick_en & acc_sum[ACC_W];

  // A software write to the accumulator beats a concurrent addition; doing
  // that while enabled corrupts the phase, which software must avoid.
  always_comb
  begin
    acc_next = acc_reg;
    inc_buf_next = inc_buf_reg;
    load_pending_next = load_pending_reg;
    load_ticks_next = load_ticks_reg;
    if (tick_en)
    begin
      acc_next = acc_sum[ACC_W-1:0];
    end
    if (wr_cycle & hit(paddr, OFF_ACCL))
    begin
      acc_next[7:0] = pwdata[7:0];
    end
    if (wr_cycle & hit(paddr, OFF_ACCH))
    begin
      acc_next[15:8] = pwdata[7:0];
    end
    if (wr_cycle & hit(paddr, OFF_ACCU))
    begin
      acc_next[19:16] = pwdata[3:0];
    end
    // Count input edges after a low-byte write; the second one loads all bytes.
    if (load_pending_reg & tick)
    begin
      if (load_ticks_reg == LOAD_TICK_COUNT - 2'h1)
      begin
        inc_buf_next = inc_reg;
        load_pending_next = 1'b0;
        load_ticks_next = 2'h0;
      end
      else
      begin
        load_ticks_next = load_ticks_reg + 2'h1;
      end
    end
    if (!ctl_en_reg)
    begin
      load_pending_next = 1'b0;
      load_ticks_next = 2'h0;
      if (inc_any_wr)
      begin
        inc_buf_next = inc_next;
      end
    end
    else if (incl_wr)
    begin
      // A fresh low-byte write restarts the count, so the last value wins.
      load_pending_next = 1'b1;
      load_ticks_next = 2'h0;
    end
  end

  // Register stage of the accumulator group.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      acc_reg <= ACC_RST;
      inc_buf_reg <= INC_RST;
      load_pending_reg <= 1'b0;
      load_ticks_reg <= 2'h0;
    end
    else
    begin
      acc_reg <= acc_next;
      inc_buf_reg <= inc_buf_next;
      load_pending_reg <= load_pending_next;
      load_ticks_reg <= load_ticks_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output shaping: toggle, pulse stretch, polarity, pin and event.

  assign span_now = pulse_span(pws_reg);
  assign raw_level = ctl_pfm_reg ? active_reg : toggle_reg;

  // An overflow during an active pulse reloads the width, so a pulse longer
  // than the overflow interval leaves the output steadily active.
  always_comb
  begin
    toggle_next = toggle_reg;
    active_next = active_reg;
    pulse_cnt_next = pulse_cnt_reg;
    if (carry)
    begin
      toggle_next = ~toggle_reg;
      active_next = 1'b1;
      pulse_cnt_next = span_now - 8'h01;
    end
    else if (tick & active_reg)
    begin
      if (pulse_cnt_reg == 8'h00)
      begin
        active_next = 1'b0;
      end
      else
      begin
        pulse_cnt_next = pulse_cnt_reg - 8'h01;
      end
    end
    if (!ctl_en_reg)
    begin
      toggle_next = 1'b0;
      active_next = 1'b0;
      pulse_cnt_next = 8'h00;
    end
    out_next = raw_level ^ ctl_pol_reg;
    pin_out_next = raw_level ^ ctl_pol_reg;
    pin_oe_next = pin_en_reg;
    event_next = carry;
  end

  // Register stage of the output group.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      toggle_reg <= 1'b0;
      active_reg <= 1'b0;
      pulse_cnt_reg <= 8'h00;
      out_reg <= 1'b0;
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
      event_reg <= 1'b0;
    end
    else
    begin
      toggle_reg <= toggle_next;
      active_reg <= active_next;
      pulse_cnt_reg <= pulse_cnt_next;
      out_reg <= out_next;
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
      event_reg <= event_next;
    end
  end

  assign osc_out = out_reg;
  assign osc_pin_out = pin_out_reg;
  assign osc_pin_oe = pin_oe_reg;
  assign accum_carry_event = event_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_armed;
    load_pending_reg && load_ticks_reg == 2'h1 && tick && ctl_en_reg && !incl_wr;
  endsequence

  sequence s_event_pulse;
    accum_carry_event ##1 !accum_carry_event;
  endsequence

  property p_acc_add;
    (tick_en && !acc_wr) |=> acc_reg == $past(acc_sum[ACC_W-1:0]);
  endproperty
  a_acc_add: assert property (p_acc_add) else $error("accumulator did not add the buffered increment");

  property p_acc_wrap;
    (tick_en && acc_sum[ACC_W] && !acc_wr) |=> ({1'b1, acc_reg} == $past(acc_sum));
  endproperty
  a_acc_wrap: assert property (p_acc_wrap) else $error("accumulator lost the remainder on overflow");

  property p_carry_event;
    carry |=> s_event_pulse;
  endproperty
  a_carry_event: assert property (p_carry_event) else $error("overflow event not a single pulse");

  property p_fdc_toggle;
    carry |=> toggle_reg != $past(toggle_reg);
  endproperty
  a_fdc_toggle: assert property (p_fdc_toggle) else $error("toggle did not flip on overflow");

  property p_pf_start;
    carry |=> active_reg && pulse_cnt_reg == $past(span_now) - 8'h01;
  endproperty
  a_pf_start: assert property (p_pf_start) else $error("pulse not started with the selected width");

  property p_pf_end;
    (active_reg && pulse_cnt_reg == 8'h00 && tick && !carry) |=> !active_reg;
  endproperty
  a_pf_end: assert property (p_pf_end) else $error("pulse outlasted its width");

  property p_pending_set;
    (ctl_en_reg && incl_wr) |=> load_pending_reg && load_ticks_reg == 2'h0;
  endproperty
  a_pending_set: assert property (p_pending_set) else $error("low byte write did not arm the buffer load");

  property p_second_edge_load;
    s_armed |=> inc_buf_reg == $past(inc_reg) && !load_pending_reg;
  endproperty
  a_second_edge_load: assert property (p_second_edge_load) else $error("buffer not loaded on second edge");

  property p_buf_hold;
    (ctl_en_reg && !(load_pending_reg && tick)) |=> inc_buf_reg == $past(inc_buf_reg);
  endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("increment buffer changed without a load");

  property p_disabled_load;
    (!ctl_en_reg && inc_any_wr) |=> inc_buf_reg == inc_reg;
  endproperty
  a_disabled_load: assert property (p_disabled_load) else $error("disabled write did not load buffer");

  property p_polarity;
    ##1 osc_out == ($past(raw_level) ^ $past(ctl_pol_reg));
  endproperty
  a_polarity: assert property (p_polarity) else $error("output level ignores polarity");

  property p_reserved_clock;
    $past(cks_reg) == CKS_RSVD |-> !tick;
  endproperty
  a_reserved_clock: assert property (p_reserved_clock) else $error("reserved clock code produced an edge");

endmodule // numeric_oscillator

// File: verification/clk_partner.sv
// Far-side model that supplies the three candidate input clocks.
module clk_partner
(
  // Candidate input clocks.
  output logic fast_internal_osc,
  output logic sys_osc_clk,
  output logic logic_cell_one_output
);
  timeunit 1ns;
  timeprecision 100ps;

  // All sources stand low between bursts, so a change of selection never fakes an edge.
  initial
  begin
    fast_internal_osc = 1'b0;
    sys_osc_clk = 1'b0;
    logic_cell_one_output = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sets the level of one source; any code above 1, code 3 included, drives logic_cell_one_output.
  task automatic drive(input int src, input logic v);
    case (src)
      0: fast_internal_osc = v;
      1: sys_osc_clk = v;
      default: logic_cell_one_output = v;
    endcase
  endtask

  // Emits n rising edges at an 80 ns period, eight system clocks apart.
  task automatic burst(input int src, input int n);
    repeat (n)
    begin
      #40;
      drive(src, 1'b1);
      #40;
      drive(src, 1'b0);
    end
  endtask
endmodule // clk_partner

// File: verification/testbench.sv
// Self-checking testbench for the numerically controlled oscillator.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import nco_pkg::*;

  logic pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic pready, pslverr, re, pol_lvl;
  logic fast_internal_osc, sys_osc_clk, logic_cell_one_output;
  logic osc_out, evt, pin_out, pin_oe;
  int bad_count, n_tests, ev_cnt, act_cnt, cyc;
  localparam logic [31:0] en_v = 32'h1 << CTL_EN_BIT;
  localparam logic [31:0] pf_v = 32'h1 << CTL_PFM_BIT;
  localparam logic [31:0] pol_v = 32'h1 << CTL_POL_BIT;

  numeric_oscillator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fast_internal_osc(fast_internal_osc), .sys_osc_clk(sys_osc_clk),
    .logic_cell_one_output(logic_cell_one_output), .osc_out(osc_out),
    .accum_carry_event(evt), .osc_pin_out(pin_out), .osc_pin_oe(pin_oe));

  clk_partner u_far (.fast_internal_osc(fast_internal_osc), .sys_osc_clk(sys_osc_clk),
    .logic_cell_one_output(logic_cell_one_output));

  ////////////////////////////////////////////////////////////////////////////////
  // Free-running 100 MHz system clock.
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Tallies carry pulses and active output cycles, and cuts a hang short.
  always @(posedge pclk)
  begin
    cyc++;
    if (evt === 1'b1)
      ev_cnt++;
    if (osc_out !== pol_lvl)
      act_cnt++;
    if (cyc == 20000)
    begin
      bad_count++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request is held until pready is seen high.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rv = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
  endtask

  // The low byte goes last because it starts the buffer transfer.
  task automatic set_inc(input logic [19:0] v);
    apb(1'b1, OFF_INCU, 32'(v[19:16]));
    apb(1'b1, OFF_INCH, 32'(v[15:8]));
    apb(1'b1, OFF_INCL, 32'(v[7:0]));
  endtask

  task automatic set_acc(input logic [19:0] v);
    apb(1'b1, OFF_ACCL, 32'(v[7:0]));
    apb(1'b1, OFF_ACCH, 32'(v[15:8]));
    apb(1'b1, OFF_ACCU, 32'(v[19:16]));
  endtask

  task automatic rd_acc(input logic [19:0] v);
    rd(OFF_ACCL, 32'(v[7:0]));
    rd(OFF_ACCH, 32'(v[15:8]));
    rd(OFF_ACCU, 32'(v[19:16]));
  endtask

  // Two edges let a fresh polarity setting reach the output before the tally restarts.
  // Clearing on the falling edge keeps clear and tally apart.
  task automatic clr();
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    ev_cnt = 0;
    act_cnt = 0;
  endtask

  task automatic settle();
    repeat (10) @(posedge pclk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(OFF_CONTROL, 32'h0);
    rd(OFF_CLOCK, 32'h0);
    rd(OFF_INCL, 32'h1);
    chk(32'(re), 32'h0);
    rd(12'h024, 32'h0);
    chk(32'(re), 32'h1);
    set_acc(20'h5A3C7);
    rd_acc(20'h5A3C7);
    set_inc(20'hB2E19);
    rd(OFF_INCU, 32'hB);
    rd(OFF_INCH, 32'h2E);
    $display("test regs done");
  endtask

  task automatic t_wrap();
    set_inc(20'h3);
    set_acc(20'hFFFFE);
    apb(1'b1, OFF_CONTROL, en_v);
    clr();
    u_far.burst(0, 1);
    settle();
    chk(32'(ev_cnt), 32'h1);
    apb(1'b1, OFF_CONTROL, 32'h0);
    rd_acc(20'h00001);
    $display("test wrap done");
  endtask

  // Old increment is used until the second tick after the low write.
  task automatic t_dbuf();
    set_inc(20'h1);
    set_acc(20'h0);
    apb(1'b1, OFF_CONTROL, en_v);
    set_inc(20'h10);
    rd(OFF_INCL, 32'h10);
    clr();
    u_far.burst(0, 4);
    settle();
    apb(1'b1, OFF_CONTROL, 32'h0);
    rd_acc(20'h00022);
    $display("test dbuf done");
  endtask

  task automatic t_fdc();
    set_inc(20'h80000);
    set_acc(20'h0);
    apb(1'b1, OFF_PIN, 32'h1);
    apb(1'b1, OFF_CONTROL, en_v);
    clr();
    u_far.burst(0, 2);
    settle();
    chk(32'(osc_out), 32'h1);
    chk(32'({pin_out, pin_oe}), 32'h3);
    rd(OFF_CONTROL, en_v | (32'h1 << CTL_OUT_BIT));
    u_far.burst(0, 2);
    settle();
    chk(32'(osc_out), 32'h0);
    chk(32'(ev_cnt), 32'h2);
    $display("test fdc done");
  endtask

  // One overflow at tick 8; active time counted in system clocks.
  task automatic t_pf();
    for (int k = 0; k < 3; k++)
    begin
      pol_lvl = (k == 1);
      apb(1'b1, OFF_CONTROL, 32'h0);
      apb(1'b1, OFF_CLOCK, 32'(k) << CLK_PWS_LSB);
      set_inc(20'h20000);
      set_acc(20'h0);
      apb(1'b1, OFF_CONTROL, en_v | pf_v | (pol_lvl ? pol_v : 32'h0));
      clr();
      u_far.burst(0, 12);
      settle();
      chk(32'(act_cnt), 32'(8 << k));
    end
    pol_lvl = 1'b0;
    // Eight-tick width outlasts the four-tick overflow interval, so the output never drops.
    apb(1'b1, OFF_CONTROL, 32'h0);
    apb(1'b1, OFF_CLOCK, 32'h3 << CLK_PWS_LSB);
    set_inc(20'h40000);
    set_acc(20'h0);
    apb(1'b1, OFF_CONTROL, en_v | pf_v);
    clr();
    u_far.burst(0, 12);
    settle();
    // The falling edge keeps this read clear of the tally's own edge.
    @(negedge pclk);
    chk(32'(act_cnt), 32'h49);
    chk(32'(ev_cnt), 32'h3);
    $display("test pf done");
  endtask

  task automatic t_src();
    apb(1'b1, OFF_CONTROL, 32'h0);
    set_inc(20'h80000);
    for (int c = 0; c < 4; c++)
    begin
      apb(1'b1, OFF_CLOCK, 32'(c));
      apb(1'b1, OFF_CONTROL, en_v);
      clr();
      for (int s = 0; s < 3; s++)
        u_far.burst(s, 2);
      settle();
      chk(32'(ev_cnt), (c < 3) ? 32'h1 : 32'h0);
      apb(1'b1, OFF_CONTROL, 32'h0);
    end
    $display("test src done");
  endtask

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset for two clocks, then each scenario in turn.
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pol_lvl = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_wrap();
    t_dbuf();
    t_fdc();
    t_pf();
    t_src();
    stop_test();
  end
endmodule // testbench
